// *** pkg/adws_pkg.sv ***
// shared constants for the adapter dma and wait-state support block
package adws_pkg;
  // ---------------------------------------------------------------
  // apb map: register index, byte address is four times the index
  // ---------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] CFG_IDX       = 12'h102;
  localparam logic [11:0] CHECK_IDX     = 12'h105;
  localparam logic [11:0] STAT_IDX      = 12'h106;
  localparam logic [11:0] PORT_IDX      = 12'h107;
  localparam logic [11:0] CFG_ADDR      = {CFG_IDX[9:0], 2'b00};
  localparam logic [11:0] CHECK_ADDR    = {CHECK_IDX[9:0], 2'b00};
  localparam logic [11:0] STAT_ADDR     = {STAT_IDX[9:0], 2'b00};
  localparam logic [11:0] PORT_ADDR     = {PORT_IDX[9:0], 2'b00};
  // ---------------------------------------------------------------
  // configuration and check register fields
  // ---------------------------------------------------------------
  localparam int          CFG_BURST_BIT = 0;
  localparam int          CFG_CHAN_BIT  = 1;
  localparam int          CFG_DIS_BIT   = 2;
  localparam int          CFG_WAIT_LSB  = 4;
  localparam int          WAIT_W        = 3;
  localparam int          CHECK_BIT     = 7;
  // ---------------------------------------------------------------
  // status register fields
  // ---------------------------------------------------------------
  localparam int          ST_READY_BIT  = 0;
  localparam int          ST_BURST_BIT  = 1;
  localparam int          ST_SINGLE_BIT = 2;
  localparam int          ST_COUNT_BIT  = 3;
  localparam int          ST_TERM_BIT   = 4;
  localparam int          ST_CHKIN_BIT  = 5;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int          OSC_PERIOD_NS = 70;
  localparam int          SCC_STROBE_NS = 250;
  localparam int          DMA_WAIT_NS   = 420;
  localparam logic [2:0]  MAX_WAITS     = 3'h6;
  localparam logic [2:0]  DMA_WAITS     = 3'(DMA_WAIT_NS / OSC_PERIOD_NS);
  localparam logic [2:0]  MIN_SCC_WAITS =
    3'((SCC_STROBE_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS);
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  PORT_RST      = 8'h00;
  localparam logic [7:0]  CFG_RST       = {1'b0, MIN_SCC_WAITS, 4'h4};
  // ---------------------------------------------------------------
  // synchronised pin vector layout
  // ---------------------------------------------------------------
  localparam int          SY_WREQ0      = 0;
  localparam int          SY_WREQ1      = 1;
  localparam int          SY_GRANT      = 2;
  localparam int          SY_STAT0      = 3;
  localparam int          SY_STAT1      = 4;
  localparam int          SY_CE         = 5;
  localparam int          SY_OSC        = 6;
  localparam int          SY_SEL        = 7;
  localparam int          SY_WS         = 8;
  localparam int          SY_SET_CHECK_N     = 9;
  localparam int          SY_CHKIN      = 10;
  localparam int          SY_DATA       = 11;
  localparam int          SY_W          = 19;
  localparam logic [18:0] SY_RST        = 19'h007ff;

  typedef enum logic {ADWS_IDLE, ADWS_COUNT} adws_wait_t;
endpackage : adws_pkg

// *** rtl/adws_top.sv ***
// adapter dma request selector, wait-state generator, output port and check line
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
// What this block does
// - one serial request drives either the burst or single arbiter request, per option bit
// - an option bit picks which serial channel may request dma
// - an option bit blocks all dma requests, both channels interrupt-driven
// - unselected channel requests are ignored, leaving it interrupt-driven
// - an active serial request is forwarded to the chosen arbiter input
// - burst request drops with the serial request so the arbiter ends the burst
// - single request drops once grant is active and a transfer starts
// - dma acknowledge is only the host accessing the serial data buffer
// - dma use stretches cycles by six wait states, burst and single alike
// - channel ready is held low for a programmed number of oscillator edges
// - the bus oscillator is the counting timebase
// - the programmed wait count spans zero to six
// - ordinary serial accesses get four oscillator edges of wait from reset, reprogrammable down to zero
// - counting starts when the serial chip enable goes active
// - a loadable down-counter reloads at zero and holds ready low while counting
// - an eight-bit latched general purpose output port
// - the port loads when its select and write strobe are both low
// - channel check is a shared open-collector level line
// - a set-check pulse asserts channel check and clears check bit 7
module adws_top
(
  input  wire logic              REF_CLK,
  input  wire logic              RST_B,
  input  wire logic              PSEL,
  input  wire logic              PENABLE,
  input  wire logic              PWRITE,
  input  wire logic [adws_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [31:0]       PWDATA,
  output logic      [31:0]       PRDATA,
  output logic                   PREADY,
  output logic                   PSLVERR,
  input  wire logic [1:0]        SERIAL_WAIT_REQUEST_N,
  input  wire logic              GRANT_ACTIVE,
  input  wire logic [1:0]        CYCLE_STATUS_LINES_N,
  input  wire logic              SERIAL_CHIP_ENABLE_N,
  input  wire logic              BUS_OSCILLATOR,
  input  wire logic              DECODED_SELECT_N,
  input  wire logic              PORT_WRITE_STROBE_N,
  input  wire logic [7:0]        PORT_DATA,
  input  wire logic              SET_CHECK_N,
  input  wire logic              CHANNEL_CHECK_N_I,
  output logic                   CHANNEL_CHECK_N_O,
  output logic                   CHANNEL_CHECK_N_OE,
  output logic                   BURST_REQUEST_IN_N,
  output logic                   SINGLE_REQUEST_IN_N,
  output logic                   CHANNEL_READY,
  output logic      [7:0]        PORT_OUT
);
  import adws_pkg::*;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [SY_W-1:0] pins;
  logic [SY_W-1:0] meta_r;
  logic [SY_W-1:0] sync_r;
  logic [SY_W-1:0] prev_r;

  assign pins = {PORT_DATA, CHANNEL_CHECK_N_I, SET_CHECK_N, PORT_WRITE_STROBE_N,
                 DECODED_SELECT_N, BUS_OSCILLATOR, SERIAL_CHIP_ENABLE_N,
                 CYCLE_STATUS_LINES_N, GRANT_ACTIVE, SERIAL_WAIT_REQUEST_N};

  genvar gi;
  generate
    for (gi = 0; gi < SY_W; gi++)
    begin : g_sync
      always_ff @(posedge REF_CLK)
      begin
        if (!RST_B)
        begin
          meta_r[gi] <= SY_RST[gi];
          sync_r[gi] <= SY_RST[gi];
          prev_r[gi] <= SY_RST[gi];
        end
        else
        begin
          meta_r[gi] <= pins[gi];
          sync_r[gi] <= meta_r[gi];
          prev_r[gi] <= sync_r[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // configuration and apb decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    hit = (a == b);
  endfunction : hit

  logic [7:0] cfg_r;
  logic       pend_r;
  logic       pready_r;
  logic       burst_mode;
  logic       chan_sel;
  logic       dma_on;
  logic [2:0] prog_waits;
  logic       acc_phase;
  logic       wr_fire;
  logic       mapped;
  logic       wr_cfg;
  logic       wr_chk;

  assign burst_mode = cfg_r[CFG_BURST_BIT];
  assign chan_sel   = cfg_r[CFG_CHAN_BIT];
  assign dma_on     = !cfg_r[CFG_DIS_BIT];
  assign prog_waits = cfg_r[CFG_WAIT_LSB +: WAIT_W];
  assign acc_phase  = PSEL && PENABLE;
  assign wr_fire    = acc_phase && pready_r && PWRITE;
  assign mapped     = hit(PADDR, CFG_ADDR) || hit(PADDR, CHECK_ADDR) ||
                      hit(PADDR, STAT_ADDR) || hit(PADDR, PORT_ADDR);
  assign wr_cfg     = wr_fire && hit(PADDR, CFG_ADDR);
  assign wr_chk     = wr_fire && hit(PADDR, CHECK_ADDR) && PWDATA[CHECK_BIT];

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
      cfg_r <= CFG_RST;
    else if (wr_cfg)
      cfg_r <= PWDATA[7:0];
  end

  // ---------------------------------------------------------------
  // dma request selector
  // ---------------------------------------------------------------
  logic req_act;
  logic xfer_start;
  logic term_r;
  logic term_nxt;
  logic burst_nxt;
  logic single_nxt;
  logic burst_r;
  logic single_r;
  logic burst_n_r;
  logic single_n_r;

  // only the chosen channel is looked at; the other stays interrupt-driven
  assign req_act    = chan_sel ? !sync_r[SY_WREQ1] : !sync_r[SY_WREQ0];
  assign xfer_start = sync_r[SY_GRANT] && (!sync_r[SY_STAT0] || !sync_r[SY_STAT1]);
  // once the transfer has started the single request stays off until the serial
  // side lets go, so one request yields exactly one transfer
  assign term_nxt   = req_act && (term_r || xfer_start);
  assign burst_nxt  = dma_on && burst_mode && req_act;
  assign single_nxt = dma_on && !burst_mode && req_act && !term_nxt;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      term_r     <= 1'b0;
      burst_r    <= 1'b0;
      single_r   <= 1'b0;
      burst_n_r  <= 1'b1;
      single_n_r <= 1'b1;
    end
    else
    begin
      term_r     <= term_nxt;
      burst_r    <= burst_nxt;
      single_r   <= single_nxt;
      burst_n_r  <= !burst_nxt;
      single_n_r <= !single_nxt;
    end
  end

  assign BURST_REQUEST_IN_N  = burst_n_r;
  assign SINGLE_REQUEST_IN_N = single_n_r;

  // ---------------------------------------------------------------
  // wait-state down-counter
  // ---------------------------------------------------------------
  adws_wait_t st_r;
  adws_wait_t st_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [2:0] eff_waits;
  logic       ce_fall;
  logic       osc_rise;
  logic       ready_r;

  // dma needs the long stretch to stop overrun; else the programmed value,
  // clamped to the supported range
  assign eff_waits = dma_on ? DMA_WAITS :
                     ((prog_waits > MAX_WAITS) ? MAX_WAITS : prog_waits);
  assign ce_fall   = prev_r[SY_CE] && !sync_r[SY_CE];
  assign osc_rise  = !prev_r[SY_OSC] && sync_r[SY_OSC];

  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      ADWS_IDLE:
      begin
        cnt_nxt = eff_waits;
        if (ce_fall && eff_waits != 3'h0)
          st_nxt = ADWS_COUNT;
      end
      ADWS_COUNT:
      begin
        if (osc_rise)
        begin
          if (cnt_r == 3'h1)
          begin
            cnt_nxt = eff_waits;
            st_nxt  = ADWS_IDLE;
          end
          else
            cnt_nxt = cnt_r - 3'h1;
        end
      end
      default:
      begin
        st_nxt  = ADWS_IDLE;
        cnt_nxt = eff_waits;
      end
    endcase
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      st_r    <= ADWS_IDLE;
      cnt_r   <= 3'h0;
      ready_r <= 1'b1;
    end
    else
    begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      ready_r <= (st_nxt != ADWS_COUNT);
    end
  end

  assign CHANNEL_READY = ready_r;

  // ---------------------------------------------------------------
  // general purpose output port
  // ---------------------------------------------------------------
  logic [7:0] port_r;
  logic       port_wr;

  // load on the leading edge of select and strobe both low, with data from the same synchroniser stage as the strobe
  assign port_wr = !sync_r[SY_SEL] && !sync_r[SY_WS] &&
                   !(!prev_r[SY_SEL] && !prev_r[SY_WS]);

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
      port_r <= PORT_RST;
    else if (port_wr)
      port_r <= sync_r[SY_DATA +: 8];
  end

  assign PORT_OUT = port_r;

  // ---------------------------------------------------------------
  // channel check
  // ---------------------------------------------------------------
  logic set_check_n;

  assign set_check_n = prev_r[SY_SET_CHECK_N] && !sync_r[SY_SET_CHECK_N];

  // a new check wins over a software clear in the same cycle
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
      pend_r <= 1'b0;
    else if (set_check_n)
      pend_r <= 1'b1;
    else if (wr_chk)
      pend_r <= 1'b0;
  end

  // open collector: only ever pulls low, never drives high
  assign CHANNEL_CHECK_N_O  = 1'b0;
  assign CHANNEL_CHECK_N_OE = pend_r;

  // ---------------------------------------------------------------
  // apb read and answer
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] prdata_r;
  logic        pslverr_r;

  assign rd_mux =
    hit(PADDR, CFG_ADDR)   ? {24'h000000, cfg_r} :
    hit(PADDR, CHECK_ADDR) ? {24'h000000, !pend_r, 7'h00} :
    hit(PADDR, STAT_ADDR)  ? {26'h0000000, sync_r[SY_CHKIN], term_r,
                              (st_r == ADWS_COUNT), single_r, burst_r, ready_r} :
    hit(PADDR, PORT_ADDR)  ? {24'h000000, port_r} : 32'h00000000;

  // one wait cycle: ready rises in the second access-phase cycle
  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= acc_phase && !pready_r;
      prdata_r  <= (acc_phase && !pready_r && !PWRITE) ? rd_mux : 32'h00000000;
      pslverr_r <= acc_phase && !pready_r && !mapped;
    end
  end

  assign PREADY  = pready_r;
  assign PRDATA  = prdata_r;
  assign PSLVERR = pslverr_r;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [3:0] low_len_r;

  always_ff @(posedge REF_CLK)
  begin
    if (!RST_B || ready_r)
      low_len_r <= 4'h0;
    else if (osc_rise && low_len_r != 4'hf)
      low_len_r <= low_len_r + 4'h1;
  end

  sequence s_ce_start;
    ce_fall && st_r == ADWS_IDLE && eff_waits != 3'h0;
  endsequence

  sequence s_ready_low;
    !CHANNEL_READY;
  endsequence

  a_dis_blocks_req: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !$past(dma_on) |-> (BURST_REQUEST_IN_N && SINGLE_REQUEST_IN_N))
    else $error("request asserted while dma disabled");

  a_one_req_only: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    !(!BURST_REQUEST_IN_N && !SINGLE_REQUEST_IN_N))
    else $error("both arbiter requests asserted");

  a_burst_follows: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (dma_on && burst_mode && $fell(req_act)) |=> BURST_REQUEST_IN_N)
    else $error("burst request did not drop with serial request");

  a_single_term: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (xfer_start && !burst_mode) |=> (SINGLE_REQUEST_IN_N [*2]))
    else $error("single request not ended at transfer start");

  a_ready_start: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    s_ce_start |=> s_ready_low)
    else $error("ready not pulled low on chip enable");

  a_ready_len: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    ($rose(CHANNEL_READY) && $past(st_r) == ADWS_COUNT) |->
      (low_len_r == {1'b0, $past(eff_waits)}))
    else $error("ready low for wrong number of oscillator edges");

  a_dma_six: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (st_r == ADWS_COUNT && dma_on) |-> cnt_r <= 3'h6 && eff_waits == 3'h6)
    else $error("dma wait count not six");

  a_reload_zero: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (st_r == ADWS_COUNT && osc_rise && cnt_r == 3'h1) |=>
      (st_r == ADWS_IDLE && cnt_r == $past(eff_waits) && CHANNEL_READY))
    else $error("counter did not reload at zero");

  a_port_load: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    port_wr |=> PORT_OUT == $past(sync_r[SY_DATA +: 8]))
    else $error("output port did not load");

  a_check_flag: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    set_check_n |=> (CHANNEL_CHECK_N_OE && !pend_r == 1'b0) [*2])
    else $error("check not raised on set pulse");

  a_apb_answer: assert property (@(posedge REF_CLK) disable iff (!RST_B)
    (PSEL && !PENABLE) ##1 (PSEL && PENABLE) |=> PREADY)
    else $error("apb answer late");
endmodule : adws_top

// *** verif/adws_host_model.sv ***
// host bus model: arbiter, motherboard dma channel and bus oscillator
`timescale 1ns/1ps
module adws_host_model
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       slow,
  input  wire logic       burst_request_in_n,
  input  wire logic       single_request_in_n,
  output logic            grant_active,
  output logic      [1:0] cycle_status_lines_n,
  output logic            bus_oscillator,
  output logic            ack_chip_enable_n
);
  logic [5:0] t_r;
  logic [5:0] lat;

  // slow mode makes the arbiter lag, so a held single request is exercised
  assign lat = slow ? 6'h08 : 6'h02;

  // free running and unrelated in phase to clk
  initial
  begin
    bus_oscillator = 1'b0;
    forever #35 bus_oscillator = ~bus_oscillator;
  end

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      t_r                  <= 6'h00;
      grant_active         <= 1'b0;
      cycle_status_lines_n <= 2'b11;
      ack_chip_enable_n    <= 1'b1;
    end
    else if (t_r == 6'h00)
    begin
      if (!burst_request_in_n || !single_request_in_n)
        t_r <= 6'h01;
    end
    else
    begin
      t_r <= t_r + 6'h01;
      if (t_r == lat)
      begin
        grant_active         <= 1'b1;
        cycle_status_lines_n <= 2'b10;
        ack_chip_enable_n    <= 1'b0;
      end
      if (t_r == lat + 6'h02)
        cycle_status_lines_n <= 2'b11;
      if (t_r == lat + 6'h1e)
      begin
        ack_chip_enable_n <= 1'b1;
        // keeps cycling while the burst request is held
        t_r               <= burst_request_in_n ? 6'h00 : 6'h01;
        grant_active      <= !burst_request_in_n;
      end
    end
  end
endmodule : adws_host_model

// *** verif/test_adws_top.sv ***
// self-checking testbench for the adapter dma and wait-state block
`timescale 1ns/1ps
module test_adws_top;
  import adws_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  serial_req_n;
  logic        grant;
  logic [1:0]  stat_n;
  logic        ce_tb_n;
  logic        ack_ce_n;
  logic        osc;
  logic        sel_n;
  logic        ws_n;
  logic [7:0]  pdata;
  logic        set_check_n_n;
  logic        chk_o;
  logic        chk_oe;
  logic        chk_wire;
  logic        burst_n;
  logic        single_n;
  logic        ready;
  logic [7:0]  port_out;
  logic        slow;
  int          err_count;
  int          n_checks;

  // open-collector wire with pull-up
  assign chk_wire = chk_oe ? chk_o : 1'b1;

  always #10 clk = ~clk;

  adws_top i_dut (.REF_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SERIAL_WAIT_REQUEST_N(serial_req_n), .GRANT_ACTIVE(grant),
    .CYCLE_STATUS_LINES_N(stat_n), .SERIAL_CHIP_ENABLE_N(ce_tb_n & ack_ce_n),
    .BUS_OSCILLATOR(osc), .DECODED_SELECT_N(sel_n), .PORT_WRITE_STROBE_N(ws_n),
    .PORT_DATA(pdata), .SET_CHECK_N(set_check_n_n), .CHANNEL_CHECK_N_I(chk_wire),
    .CHANNEL_CHECK_N_O(chk_o), .CHANNEL_CHECK_N_OE(chk_oe), .BURST_REQUEST_IN_N(burst_n),
    .SINGLE_REQUEST_IN_N(single_n), .CHANNEL_READY(ready), .PORT_OUT(port_out));

  adws_host_model i_host (.clk(clk), .rst_b(rst_b), .slow(slow),
    .burst_request_in_n(burst_n), .single_request_in_n(single_n), .grant_active(grant),
    .cycle_status_lines_n(stat_n), .bus_oscillator(osc), .ack_chip_enable_n(ack_ce_n));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    @(negedge clk);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic check_in(input int got, input int lo, input int hi);
    n_checks++;
    if (got < lo || got > hi)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask : check_in

  task automatic acc(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     input logic [31:0] mask, input logic [31:0] exp, input logic exp_err);
    int          n;
    logic [31:0] rd;
    logic        er;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      err_count++;
    if (!wr)
      check(rd & mask, exp);
    check({31'h0, er}, {31'h0, exp_err});
  endtask : acc

  task automatic count_low(input int m, output int lo);
    lo = 0;
    repeat (m)
    begin
      @(posedge clk);
      if (ready === 1'b0)
        lo++;
    end
  endtask : count_low

  // ready low cycles at 20 ns against a 70 ns count, with sync slack
  task automatic wait_test(input logic [7:0] cfg, input int n);
    int lo;
    acc(1'b1, CFG_ADDR, {24'h0, cfg}, 32'h0, 32'h0, 1'b0);
    @(posedge clk);
    ce_tb_n <= 1'b0;
    count_low(40, lo);
    ce_tb_n <= 1'b1;
    check_in(lo, (n == 0) ? 0 : n * 7 / 2 - 4, (n == 0) ? 0 : n * 7 / 2 + 4);
  endtask : wait_test

  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    int lo;
    {rst_b, psel, penable, pwrite, paddr, pwdata, slow, pdata} = '0;
    {ce_tb_n, sel_n, ws_n, set_check_n_n} = 4'hf;
    serial_req_n = 2'b11;
    err_count = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    check({20'h0, port_out, ready, burst_n, single_n, chk_oe}, {20'h0, PORT_RST, 4'he});
    acc(1'b0, CFG_ADDR, 32'h0, 32'hff, 32'h44, 1'b0);
    acc(1'b0, CHECK_ADDR, 32'h0, 32'h80, 32'h80, 1'b0);
    acc(1'b0, 12'h000, 32'h0, 32'hffffffff, 32'h0, 1'b1);
    acc(1'b1, 12'h004, 32'hff, 32'h0, 32'h0, 1'b1);
    serial_req_n <= 2'b00;
    repeat (8) @(posedge clk);
    check({30'h0, burst_n, single_n}, 32'h3);
    serial_req_n <= 2'b11;
    wait_test(8'h04, 0);
    wait_test(8'h34, 3);
    wait_test(8'h44, 4);
    wait_test(8'h44, 4);
    wait_test(8'h74, 6);
    wait_test(8'h00, 6);
    wait_test(8'h01, 6);
    // burst on channel a, channel b ignored
    serial_req_n <= 2'b01;
    repeat (8) @(posedge clk);
    check({30'h0, burst_n, single_n}, 32'h3);
    serial_req_n <= 2'b10;
    repeat (4) @(posedge clk);
    check({30'h0, burst_n, single_n}, 32'h1);
    count_low(120, lo);
    check_in(lo, 40, 110);
    serial_req_n <= 2'b11;
    repeat (4) @(posedge clk);
    check({31'h0, burst_n}, 32'h1);
    repeat (40) @(posedge clk);
    check({31'h0, grant}, 32'h0);
    // single transfers on channel b behind a slow arbiter
    acc(1'b1, CFG_ADDR, 32'h02, 32'h0, 32'h0, 1'b0);
    slow <= 1'b1;
    serial_req_n <= 2'b10;
    repeat (8) @(posedge clk);
    check({30'h0, burst_n, single_n}, 32'h3);
    serial_req_n <= 2'b01;
    repeat (4) @(posedge clk);
    check({30'h0, burst_n, single_n}, 32'h2);
    repeat (16) @(posedge clk);
    check({31'h0, single_n}, 32'h1);
    acc(1'b0, STAT_ADDR, 32'h0, 32'h16, 32'h10, 1'b0);
    serial_req_n <= 2'b11;
    repeat (40) @(posedge clk);
    // output port needs both select and strobe
    pdata <= 8'ha5;
    ws_n  <= 1'b0;
    repeat (6) @(posedge clk);
    check({24'h0, port_out}, 32'h0);
    sel_n <= 1'b0;
    repeat (6) @(posedge clk);
    {sel_n, ws_n} <= 2'b11;
    repeat (2) @(posedge clk);
    pdata <= 8'h5a;
    repeat (6) @(posedge clk);
    check({24'h0, port_out}, 32'ha5);
    acc(1'b0, PORT_ADDR, 32'h0, 32'hff, 32'ha5, 1'b0);
    // channel check raised, identified and cleared
    set_check_n_n <= 1'b0;
    repeat (4) @(posedge clk);
    set_check_n_n <= 1'b1;
    repeat (4) @(posedge clk);
    check({30'h0, chk_oe, chk_wire}, 32'h2);
    acc(1'b0, CHECK_ADDR, 32'h0, 32'h80, 32'h0, 1'b0);
    acc(1'b0, STAT_ADDR, 32'h0, 32'h20, 32'h0, 1'b0);
    acc(1'b1, CHECK_ADDR, 32'h80, 32'h0, 32'h0, 1'b0);
    repeat (4) @(posedge clk);
    check({31'h0, chk_oe}, 32'h0);
    acc(1'b0, CHECK_ADDR, 32'h0, 32'h80, 32'h80, 1'b0);
    finish_test();
  end

  // a hang ends the run well past the expected several hundred cycles
  initial
  begin
    #200000;
    err_count++;
    finish_test();
  end
endmodule : test_adws_top
